// ---- rtl/core_special_registers.v ----
// core special-function registers: indirect access, pc low, table, status
`timescale 1ns/1ns
`include "core_regs_map.vh"

module core_special_registers
#(
    parameter SECTOR_BITS = 3,
    parameter PC_BITS     = 13,
    parameter PROG_BITS   = 16
)
(
    // clock and reset
    input  wire                      core_clk,
    input  wire                      rst,
    // execution unit data access
    input  wire                      ex_valid,
    input  wire                      ex_write,
    input  wire [SECTOR_BITS+7:0]    ex_addr,
    input  wire [7:0]                ex_wdata,
    output wire [7:0]                ex_rdata,
    output wire                      ex_hold,
    // data memory
    output reg                       mem_valid,
    output reg                       mem_write,
    output reg  [SECTOR_BITS+7:0]    mem_addr,
    output reg  [7:0]                mem_wdata,
    input  wire [7:0]                mem_rdata,
    // alu result and flags
    input  wire                      alu_valid,
    input  wire [3:0]                alu_op,
    input  wire [7:0]                alu_a,
    input  wire [7:0]                alu_b,
    output wire [7:0]                alu_result,
    output wire [7:0]                status,
    // system events
    input  wire                      halt_exec,
    input  wire                      watchdog_clear_instruction,
    input  wire                      watchdog_timer_expired,
    // program counter
    input  wire [PC_BITS-1:0]        pc_now,
    output reg                       pcl_jump,
    output reg  [PC_BITS-1:0]        pcl_target,
    // table read
    input  wire                      tbl_read,
    output reg                       prog_rd,
    output wire [15:0]               prog_addr,
    input  wire [PROG_BITS-1:0]      prog_data,
    output reg                       tbl_done,
    output reg  [7:0]                tbl_low,
    // avalon-mm slave
    input  wire [3:0]                avs_address,
    input  wire                      avs_read,
    input  wire                      avs_write,
    input  wire [31:0]               avs_writedata,
    input  wire [3:0]                avs_byteenable,
    output reg  [31:0]               avs_readdata,
    output wire                      avs_waitrequest
);

    // ==========================================================
    // storage
    // ==========================================================
    reg [7:0]  sector_zero_pointer_q;
    reg [7:0]  pointer_one_offset_q;
    reg [7:0]  pointer_one_sector_q;
    reg [7:0]  pointer_two_offset_q;
    reg [7:0]  pointer_two_sector_q;
    reg [7:0]  table_pointer_low_q;
    reg [7:0]  table_pointer_high_q;
    reg [7:0]  table_result_high_q;
    reg [7:0]  status_q;
    reg [7:0]  status_d;
    reg        hold_q;
    reg        tbl_wait_q;
    reg [7:0]  local_rdata_q;
    reg        rd_from_mem_q;
    reg        av_ack_q;
    reg        self_ref;

    // ==========================================================
    // address decode
    // ==========================================================
    wire [SECTOR_BITS-1:0] ex_sector = ex_addr[SECTOR_BITS+7:8];
    wire [7:0]             ex_off    = ex_addr[7:0];
    wire                   in_zero   = (ex_sector == {SECTOR_BITS{1'b0}});

    wire hit_p0   = in_zero && (ex_off == `ADR_PORT_FIRST);
    wire hit_p1   = in_zero && (ex_off == `ADR_PORT_SECOND);
    wire hit_p2   = in_zero && (ex_off == `ADR_PORT_THIRD);
    wire hit_mp0  = in_zero && (ex_off == `ADR_ZERO_POINTER);
    wire hit_m1l  = in_zero && (ex_off == `ADR_PTR1_OFFSET);
    wire hit_m1h  = in_zero && (ex_off == `ADR_PTR1_SECTOR);
    wire hit_m2l  = in_zero && (ex_off == `ADR_PTR2_OFFSET);
    wire hit_m2h  = in_zero && (ex_off == `ADR_PTR2_SECTOR);
    wire hit_pcl  = in_zero && (ex_off == `ADR_PC_LOW);
    wire hit_tbl  = in_zero && (ex_off == `ADR_TBL_LOW);
    wire hit_tbh  = in_zero && (ex_off == `ADR_TBL_HIGH);
    wire hit_tbr  = in_zero && (ex_off == `ADR_TBL_RESULT);
    wire hit_st   = in_zero && (ex_off == `ADR_STATUS);
    wire hit_local = hit_mp0 | hit_m1l | hit_m1h | hit_m2l | hit_m2h |
                     hit_pcl | hit_tbl | hit_tbh | hit_tbr | hit_st;
    wire hit_port  = hit_p0 | hit_p1 | hit_p2;

    // ==========================================================
    // data memory redirection
    // ==========================================================
    // one access per cycle, so no direct register to register move
    // single operand access
    always @*
    begin
        mem_valid = ex_valid && !hit_local && !hold_q;
        mem_write = ex_write;
        mem_wdata = ex_wdata;
        mem_addr  = ex_addr;
        if (hit_p0)
            // first port fixed to sector zero
            mem_addr = {{SECTOR_BITS{1'b0}}, sector_zero_pointer_q};
        else if (hit_p1)
            mem_addr = {pointer_one_sector_q[SECTOR_BITS-1:0],
                        pointer_one_offset_q};
        else if (hit_p2)
            mem_addr = {pointer_two_sector_q[SECTOR_BITS-1:0],
                        pointer_two_offset_q};
        // extended address passes sector and offset as given
        else
            mem_addr = ex_addr;
        // a port aimed at a port holds nothing, access dropped
        self_ref = hit_port &&
                   (mem_addr[SECTOR_BITS+7:8] == {SECTOR_BITS{1'b0}}) &&
                   ((mem_addr[7:0] == `ADR_PORT_FIRST) ||
                    (mem_addr[7:0] == `ADR_PORT_SECOND) ||
                    (mem_addr[7:0] == `ADR_PORT_THIRD));
        if (self_ref)
            mem_valid = 1'b0;
    end

    // ==========================================================
    // read path
    // ==========================================================
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            local_rdata_q <= 8'h00;
            rd_from_mem_q <= 1'b0;
        end
        else if (ex_valid && !ex_write)
        begin
            rd_from_mem_q <= !hit_local && !self_ref;
            case (1'b1)
                hit_mp0: local_rdata_q <= sector_zero_pointer_q;
                hit_m1l: local_rdata_q <= pointer_one_offset_q;
                hit_m1h: local_rdata_q <= pointer_one_sector_q;
                hit_m2l: local_rdata_q <= pointer_two_offset_q;
                hit_m2h: local_rdata_q <= pointer_two_sector_q;
                hit_pcl: local_rdata_q <= pc_now[7:0];
                hit_tbl: local_rdata_q <= table_pointer_low_q;
                hit_tbh: local_rdata_q <= table_pointer_high_q;
                hit_tbr: local_rdata_q <= table_result_high_q;
                hit_st:  local_rdata_q <= status_q;
                default: local_rdata_q <= 8'h00;
            endcase
        end
    end

    assign ex_rdata = rd_from_mem_q ? mem_rdata : local_rdata_q;
    assign ex_hold  = hold_q | tbl_wait_q;

    // ==========================================================
    // pointer and table registers
    // ==========================================================
    wire ex_wr = ex_valid && ex_write && !hold_q;

    always @(posedge core_clk)
    begin
        if (rst)
        begin
            sector_zero_pointer_q <= 8'h00;
            pointer_one_offset_q  <= 8'h00;
            pointer_one_sector_q  <= 8'h00;
            pointer_two_offset_q  <= 8'h00;
            pointer_two_sector_q  <= 8'h00;
            table_pointer_low_q   <= 8'h00;
            table_pointer_high_q  <= 8'h00;
        end
        else if (ex_wr)
        begin
            if (hit_mp0)
                sector_zero_pointer_q <= ex_wdata;
            if (hit_m1l)
                pointer_one_offset_q <= ex_wdata;
            if (hit_m1h)
                pointer_one_sector_q <= ex_wdata;
            if (hit_m2l)
                pointer_two_offset_q <= ex_wdata;
            if (hit_m2h)
                pointer_two_sector_q <= ex_wdata;
            if (hit_tbl)
                table_pointer_low_q <= ex_wdata;
            if (hit_tbh)
                table_pointer_high_q <= ex_wdata;
        end
    end

    // port writes reach memory only, no local storage
    // fetch word, split high and low bytes
    assign prog_addr = {table_pointer_high_q, table_pointer_low_q};

    always @(posedge core_clk)
    begin
        if (rst)
        begin
            prog_rd             <= 1'b0;
            tbl_wait_q          <= 1'b0;
            tbl_done            <= 1'b0;
            tbl_low             <= 8'h00;
            table_result_high_q <= 8'h00;
        end
        else
        begin
            prog_rd  <= tbl_read && !tbl_wait_q;
            tbl_done <= 1'b0;
            if (tbl_read && !tbl_wait_q)
                tbl_wait_q <= 1'b1;
            else if (tbl_wait_q && !prog_rd)
            begin
                tbl_wait_q          <= 1'b0;
                tbl_done            <= 1'b1;
                tbl_low             <= prog_data[7:0];
                table_result_high_q <= prog_data[PROG_BITS-1:8];
            end
        end
    end

    // ==========================================================
    // program counter low byte
    // ==========================================================
    // low byte replaced, page kept
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            pcl_jump   <= 1'b0;
            pcl_target <= {PC_BITS{1'b0}};
            hold_q     <= 1'b0;
        end
        else
        begin
            pcl_jump <= ex_wr && hit_pcl;
            hold_q   <= ex_wr && hit_pcl;
            if (ex_wr && hit_pcl)
                pcl_target <= {pc_now[PC_BITS-1:8], ex_wdata};
        end
    end

    // ==========================================================
    // status flags
    // ==========================================================
    wire [7:0] f_res;
    wire       f_c;
    wire       f_ac;
    wire       f_z;
    wire       f_ov;
    wire       f_sc;
    wire       f_cz;
    wire       f_arith;
    wire       f_upd_c;
    wire       f_upd_z;

    alu_flag_unit u_flags
    (
        .op        (alu_op),
        .a         (alu_a),
        .b         (alu_b),
        .c_in      (status_q[`ST_C]),
        .cz_in     (status_q[`ST_CZ]),
        .result    (f_res),
        .c_out     (f_c),
        .ac_out    (f_ac),
        .z_out     (f_z),
        .ov_out    (f_ov),
        .sc_out    (f_sc),
        .cz_out    (f_cz),
        .upd_arith (f_arith),
        .upd_c     (f_upd_c),
        .upd_z     (f_upd_z)
    );

    assign alu_result = f_res;
    assign status     = status_q;

    // avalon control: bit0 freezes flag writes from the avalon path, core writes still land
    reg        av_status_lock_q;
    wire       av_wr_st = avs_write && av_ack_q &&
                          (avs_address == `AV_STATUS) && avs_byteenable[0];

    always @*
    begin
        status_d = status_q;
        // writes keep power-down and watchdog bits
        if (ex_wr && hit_st)
            status_d = (status_q & ~`STATUS_WR_MASK) |
                       (ex_wdata & `STATUS_WR_MASK);
        else if (av_wr_st && !av_status_lock_q)
            status_d = (status_q & ~`STATUS_WR_MASK) |
                       (avs_writedata[7:0] & `STATUS_WR_MASK);
        if (alu_valid)
        begin
            if (f_upd_c)
                status_d[`ST_C] = f_c;
            if (f_upd_z)
                status_d[`ST_Z] = f_z;
            if (f_arith)
            begin
                status_d[`ST_AC] = f_ac;
                status_d[`ST_OV] = f_ov;
                status_d[`ST_SC] = f_sc;
            end
            status_d[`ST_CZ] = f_cz;
        end
        if (watchdog_clear_instruction)
            status_d[`ST_PD] = 1'b0;
        else if (halt_exec)
            status_d[`ST_PD] = 1'b1;
        if (watchdog_timer_expired)
            status_d[`ST_TO] = 1'b1;
        else if (watchdog_clear_instruction || halt_exec)
            status_d[`ST_TO] = 1'b0;
    end

    // status only changes here, never stacked
    always @(posedge core_clk)
    begin
        if (rst)
            status_q <= `STATUS_RESET;
        else
            status_q <= status_d;
    end

    // ==========================================================
    // avalon-mm slave, one wait state on every access
    // ==========================================================
    assign avs_waitrequest = (avs_read || avs_write) && !av_ack_q;

    always @(posedge core_clk)
    begin
        if (rst)
        begin
            av_ack_q         <= 1'b0;
            avs_readdata     <= 32'h0000_0000;
            av_status_lock_q <= `CONTROL_RESET;
        end
        else
        begin
            av_ack_q <= (avs_read || avs_write) && !av_ack_q;
            if (avs_write && av_ack_q &&
                avs_address == `AV_CONTROL && avs_byteenable[0])
                av_status_lock_q <= avs_writedata[0];
            if (avs_read && !av_ack_q)
            begin
                case (avs_address)
                    `AV_STATUS:   avs_readdata <= {24'h00_0000, status_q};
                    `AV_POINTERS: avs_readdata <= {pointer_two_offset_q,
                                                   pointer_one_sector_q,
                                                   pointer_one_offset_q,
                                                   sector_zero_pointer_q};
                    `AV_TABLE:    avs_readdata <= {8'h00,
                                                   table_result_high_q,
                                                   table_pointer_high_q,
                                                   table_pointer_low_q};
                    `AV_CONTROL:  avs_readdata <= {31'h0000_0000,
                                                   av_status_lock_q};
                    default:      avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

// ---- rtl/core_regs_map.vh ----
// constants for the core special-function register block
`ifndef CORE_REGS_MAP_VH
`define CORE_REGS_MAP_VH

// direct offsets of the special registers in sector zero
`define ADR_PORT_FIRST      8'h00
`define ADR_ZERO_POINTER    8'h01
`define ADR_PORT_SECOND     8'h02
`define ADR_PTR1_OFFSET     8'h03
`define ADR_PTR1_SECTOR     8'h04
`define ADR_PC_LOW          8'h06
`define ADR_TBL_LOW         8'h07
`define ADR_TBL_RESULT      8'h08
`define ADR_TBL_HIGH        8'h09
`define ADR_STATUS          8'h0a
`define ADR_PORT_THIRD      8'h0c
`define ADR_PTR2_OFFSET     8'h0d
`define ADR_PTR2_SECTOR     8'h0e

// status bit positions
`define ST_SC   7
`define ST_CZ   6
`define ST_TO   5
`define ST_PD   4
`define ST_OV   3
`define ST_Z    2
`define ST_AC   1
`define ST_C    0
`define STATUS_RESET     8'h00
`define STATUS_WR_MASK   8'hcf

// alu operation codes
`define OP_ADD  4'h0
`define OP_ADC  4'h1
`define OP_SUB  4'h2
`define OP_SBC  4'h3
`define OP_AND  4'h4
`define OP_OR   4'h5
`define OP_XOR  4'h6
`define OP_RLC  4'h7
`define OP_RRC  4'h8

// avalon register byte addresses
`define AV_STATUS    4'h0
`define AV_POINTERS  4'h4
`define AV_TABLE     4'h8
`define AV_CONTROL   4'hc
`define CONTROL_RESET 1'b0

`endif

// ---- rtl/alu_flag_unit.v ----
// flag computation for one alu operation
`timescale 1ns/1ns
`include "core_regs_map.vh"

module alu_flag_unit
(
    // operation
    input  wire [3:0] op,
    input  wire [7:0] a,
    input  wire [7:0] b,
    input  wire       c_in,
    input  wire       cz_in,
    // results
    output reg  [7:0] result,
    output reg        c_out,
    output reg        ac_out,
    output reg        z_out,
    output reg        ov_out,
    output reg        sc_out,
    output reg        cz_out,
    output reg        upd_arith,
    output reg        upd_c,
    output reg        upd_z
);

    reg [7:0] bb;
    reg       ci;
    reg [8:0] sum;
    reg [4:0] nib;
    reg [7:0] low7;
    reg       sub;

    always @*
    begin
        sub  = (op == `OP_SUB) || (op == `OP_SBC);
        // subtraction as a plus not-b plus one (sbc: plus carry in), carry then means no borrow
        bb   = sub ? ~b : b;
        case (op)
            `OP_ADC, `OP_SBC: ci = c_in;
            `OP_SUB:          ci = 1'b1;
            default:          ci = 1'b0;
        endcase
        sum  = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
        nib  = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
        low7 = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h00, ci};
        result    = sum[7:0];
        c_out     = sum[8];
        ac_out    = nib[4];
        // carry in vs out of top bit
        ov_out    = low7[7] ^ sum[8];
        upd_arith = 1'b1;
        upd_c     = 1'b1;
        upd_z     = 1'b1;
        cz_out    = cz_in;
        case (op)
            `OP_AND: result = a & b;
            `OP_OR:  result = a | b;
            `OP_XOR: result = a ^ b;
            `OP_RLC:
            begin
                result = {a[6:0], c_in};
                c_out  = a[7];
            end
            `OP_RRC:
            begin
                result = {c_in, a[7:1]};
                c_out  = a[0];
            end
            default: result = sum[7:0];
        endcase
        if (op > `OP_SBC)
            upd_arith = 1'b0;
        if (op == `OP_AND || op == `OP_OR || op == `OP_XOR)
            upd_c = 1'b0;
        if (op == `OP_RLC || op == `OP_RRC)
            upd_z = 1'b0;
        z_out  = (result == 8'h00);
        sc_out = ov_out ^ result[7];
        if (op == `OP_SUB)
            cz_out = z_out;
        else if (op == `OP_SBC)
            cz_out = cz_in & z_out;
        else
            cz_out = cz_in;
    end

endmodule

// ---- test/core_special_registers_assertions.sv ----
// checker for the core special-function register block
`timescale 1ns/1ns
module core_special_registers_assertions
(
    // clock, reset and events
    input wire       core_clk,
    input wire       rst,
    input wire       halt_exec,
    input wire       watchdog_clear_instruction,
    input wire       watchdog_timer_expired,
    // flags and handshakes
    input wire       alu_valid,
    input wire [3:0] alu_op,
    input wire [7:0] status,
    input wire       pcl_jump,
    input wire       ex_hold,
    input wire       tbl_read,
    input wire       prog_rd,
    input wire       tbl_done,
    input wire       avs_read,
    input wire       avs_write,
    input wire       avs_waitrequest
);
    // ====
    // properties
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    wire clr = watchdog_clear_instruction;
    wire tmo = watchdog_timer_expired;
    property p_pd_set; halt_exec && !clr |=> status[4]; endproperty
    a_pd_set: assert property (p_pd_set) else $error("pd not set");
    property p_pd_clr; clr |=> !status[4]; endproperty
    a_pd_clr: assert property (p_pd_clr) else $error("pd kept");
    property p_pd_keep; !halt_exec && !clr |=> $stable(status[4]); endproperty
    a_pd_keep: assert property (p_pd_keep) else $error("pd moved");
    property p_to_set; tmo |=> status[5]; endproperty
    a_to_set: assert property (p_to_set) else $error("to not set");
    property p_to_clr; (clr || halt_exec) && !tmo |=> !status[5]; endproperty
    a_to_clr: assert property (p_to_clr) else $error("to kept");
    property p_to_keep; !halt_exec && !clr && !tmo |=> $stable(status[5]);
    endproperty
    a_to_keep: assert property (p_to_keep) else $error("to moved");
    property p_pcl; pcl_jump |-> ex_hold ##1 !pcl_jump; endproperty
    a_pcl: assert property (p_pcl) else $error("bad dummy cycle");
    property p_tbl; tbl_read && !ex_hold |=> prog_rd && ex_hold ##2 tbl_done;
    endproperty
    a_tbl: assert property (p_tbl) else $error("bad table read");
    property p_cz;
        alu_valid && alu_op != 4'h2 && alu_op != 4'h3 && !avs_write
        |=> $stable(status[6]);
    endproperty
    a_cz: assert property (p_cz) else $error("cz moved");
    property p_bus;
        $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_bus: assert property (p_bus) else $error("bad wait");
    c_halt: cover property (halt_exec);
    c_jump: cover property (pcl_jump);
    c_tbl: cover property (tbl_done);
endmodule
bind core_special_registers core_special_registers_assertions chk
(
    .core_clk(core_clk), .rst(rst), .halt_exec(halt_exec),
    .watchdog_clear_instruction(watchdog_clear_instruction),
    .watchdog_timer_expired(watchdog_timer_expired),
    .alu_valid(alu_valid), .alu_op(alu_op), .status(status),
    .pcl_jump(pcl_jump), .ex_hold(ex_hold), .tbl_read(tbl_read),
    .prog_rd(prog_rd), .tbl_done(tbl_done), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest)
);

// ---- test/core_mem_model.sv ----
// data and program memory model facing the register block
`timescale 1ns/1ns
module core_mem_model
(
    // clock
    input wire        core_clk,
    // data memory
    input wire        mem_valid,
    input wire        mem_write,
    input wire [10:0] mem_addr,
    input wire [7:0]  mem_wdata,
    output reg [7:0]  mem_rdata,
    // program memory
    input wire        prog_rd,
    input wire [15:0] prog_addr,
    output reg [15:0] prog_data
);
    reg [7:0] mem [0:2047];
    initial
    begin
        mem_rdata = 8'h00;
        prog_data = 16'h0000;
    end
    // idle outputs toggle so stale data never passes for an answer
    always @(posedge core_clk)
    begin
        if (mem_valid && mem_write)
            mem[mem_addr] <= mem_wdata;
        mem_rdata <= (mem_valid && !mem_write) ? mem[mem_addr] : ~mem_rdata;
        prog_data <= prog_rd ? {prog_addr[7:0], ~prog_addr[15:8]} : ~prog_data;
    end
endmodule

// ---- test/core_special_registers_bench.sv ----
// self-checking bench for the core special-function register block
`timescale 1ns/1ns
module core_special_registers_bench;
    reg         core_clk = 1'b0, rst = 1'b1, tbl_read = 1'b0;
    reg         ex_valid = 1'b0, ex_write = 1'b0, alu_valid = 1'b0;
    reg         avs_read = 1'b0, avs_write = 1'b0;
    reg  [2:0]  evt = 3'h0;
    reg  [10:0] ex_addr = 11'h000;
    reg  [7:0]  ex_wdata = 8'h00, alu_a = 8'h00, alu_b = 8'h00, q;
    reg  [3:0]  alu_op = 4'h0, avs_address = 4'h0;
    reg  [31:0] avs_writedata = 32'h0, rd;
    wire [7:0]  ex_rdata, mem_wdata, mem_rdata, status, tbl_low, res;
    wire [10:0] mem_addr;
    wire [12:0] pcl_target;
    wire [15:0] prog_addr, prog_data;
    wire [31:0] avs_readdata;
    wire        ex_hold, mem_valid, mem_write, pcl_jump, prog_rd, tbl_done;
    wire        avs_waitrequest;
    integer     bad_count = 0, num_checks = 0, i;
    core_special_registers DUT
    (
        .core_clk(core_clk), .rst(rst), .ex_valid(ex_valid),
        .ex_write(ex_write), .ex_addr(ex_addr), .ex_wdata(ex_wdata),
        .ex_rdata(ex_rdata), .ex_hold(ex_hold), .mem_valid(mem_valid),
        .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .alu_valid(alu_valid), .alu_op(alu_op),
        .alu_a(alu_a), .alu_b(alu_b), .alu_result(res), .status(status),
        .halt_exec(evt[2]), .watchdog_clear_instruction(evt[1]),
        .watchdog_timer_expired(evt[0]), .pc_now(13'h1234),
        .pcl_jump(pcl_jump), .pcl_target(pcl_target), .tbl_read(tbl_read),
        .prog_rd(prog_rd), .prog_addr(prog_addr), .prog_data(prog_data),
        .tbl_done(tbl_done), .tbl_low(tbl_low), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
    );
    core_mem_model mem_i
    (
        .core_clk(core_clk), .mem_valid(mem_valid), .mem_write(mem_write),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .prog_rd(prog_rd), .prog_addr(prog_addr), .prog_data(prog_data)
    );
    // ====
    // tasks
    task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
        num_checks = num_checks + 1;
        if (g !== e)
        begin
            bad_count = bad_count + 1;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    end
    endtask
    task end_of_test;
    begin
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask
    // request held until the edge that sees waitrequest low
    task bus(input w, input [3:0] a, input [31:0] d);
    begin
        @(posedge core_clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        do
            @(posedge core_clk);
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        #1;
    end
    endtask
    task ex(input w, input [10:0] a, input [7:0] d);
    begin
        @(posedge core_clk);
        ex_valid <= 1'b1;
        ex_write <= w;
        ex_addr <= a;
        ex_wdata <= d;
        @(posedge core_clk);
        ex_valid <= 1'b0;
        #1 q = ex_rdata;
    end
    endtask
    task alu(input [3:0] op, input [7:0] a, input [7:0] b, input [7:0] e);
    begin
        @(posedge core_clk);
        alu_valid <= 1'b1;
        alu_op <= op;
        alu_a <= a;
        alu_b <= b;
        @(posedge core_clk);
        alu_valid <= 1'b0;
        #1 chk("status", {24'h0, e}, {24'h0, status});
    end
    endtask
    task ev(input [2:0] v, input [7:0] e);
    begin
        @(posedge core_clk);
        evt <= v;
        @(posedge core_clk);
        evt <= 3'h0;
        #1 chk("status", {24'h0, e}, {24'h0, status});
    end
    endtask
    // ====
    // sequence
    always #5 core_clk = ~core_clk;
    initial
    begin
        #100000;
        bad_count = bad_count + 1;
        end_of_test;
    end
    initial
    begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        #1 chk("reset", 32'h0, {24'h0, status});
        ex(1'b1, 11'h001, 8'h00);
        ex(1'b0, 11'h000, 8'h00);
        chk("port self", 32'h0, {24'h0, q});
        ex(1'b1, 11'h001, 8'h40);
        ex(1'b1, 11'h003, 8'h40);
        ex(1'b1, 11'h004, 8'h01);
        ex(1'b1, 11'h00d, 8'h40);
        ex(1'b1, 11'h00e, 8'h02);
        ex(1'b1, 11'h000, 8'ha1);
        ex(1'b1, 11'h002, 8'hb2);
        ex(1'b1, 11'h00c, 8'hc3);
        ex(1'b1, 11'h1f0, 8'h77);
        chk("sector0", 32'ha1, {24'h0, mem_i.mem[11'h040]});
        chk("sector1", 32'hb2, {24'h0, mem_i.mem[11'h140]});
        chk("sector2", 32'hc3, {24'h0, mem_i.mem[11'h240]});
        chk("extended", 32'h77, {24'h0, mem_i.mem[11'h1f0]});
        ex(1'b0, 11'h002, 8'h00);
        chk("port read", 32'hb2, {24'h0, q});
        bus(1'b0, 4'h4, 32'h0);
        chk("pointers", 32'h40014040, rd);
        ex(1'b1, 11'h006, 8'h56);
        chk("jump", 32'h1, {31'h0, pcl_jump & ex_hold});
        chk("target", 32'h1256, {19'h0, pcl_target});
        ex(1'b1, 11'h007, 8'h34);
        ex(1'b1, 11'h009, 8'h12);
        @(posedge core_clk);
        tbl_read <= 1'b1;
        @(posedge core_clk);
        tbl_read <= 1'b0;
        #1;
        for (i = 0; i < 8 && tbl_done !== 1'b1; i = i + 1)
            #10;
        chk("tbl low", 32'hed, {24'h0, tbl_low});
        bus(1'b0, 4'h8, 32'h0);
        chk("tbl regs", 32'h00341234, rd);
        alu(4'h0, 8'h7f, 8'h01, 8'h0a);
        chk("alu result", 32'h80, {24'h0, res});
        alu(4'h2, 8'h05, 8'h05, 8'h47);
        alu(4'h4, 8'hf0, 8'hf0, 8'h43);
        alu(4'h2, 8'h80, 8'h01, 8'h89);
        alu(4'h8, 8'h02, 8'h00, 8'h88);
        alu(4'h1, 8'h00, 8'h00, 8'h04);
        alu(4'h3, 8'h03, 8'h02, 8'h07);
        alu(4'h5, 8'h01, 8'h00, 8'h03);
        alu(4'h6, 8'haa, 8'haa, 8'h07);
        alu(4'h7, 8'h00, 8'h00, 8'h06);
        ev(3'b100, 8'h16);
        bus(1'b1, 4'h0, 32'hff);
        chk("status", 32'hdf, {24'h0, status});
        ev(3'b001, 8'hff);
        bus(1'b1, 4'h0, 32'h00);
        chk("status", 32'h30, {24'h0, status});
        ev(3'b010, 8'h00);
        bus(1'b1, 4'hc, 32'h1);
        bus(1'b1, 4'h0, 32'hff);
        bus(1'b0, 4'h0, 32'h0);
        chk("locked", 32'h0, rd);
        bus(1'b0, 4'h2, 32'h0);
        chk("unmapped", 32'h0, rd);
        end_of_test;
    end
endmodule
